/* siom_consts.vh */
// Constants for the servo I/O signal mapping block.
`ifndef SIOM_CONSTS_VH
`define SIOM_CONSTS_VH

// Register addresses.
`define SIOM_ADDR_INPUT_ALLOC_A        16'h3361
`define SIOM_ADDR_INPUT_ALLOC_B        16'h3362
`define SIOM_ADDR_OUTPUT_ALLOC         16'h3363
`define SIOM_ADDR_BUS_INPUT_LOW_EN     16'h3364
`define SIOM_ADDR_BUS_INPUT_HIGH_EN    16'h3365
`define SIOM_ADDR_INPUT_FILTER_CYCLES  16'h3366
`define SIOM_ADDR_ALARM_OUTPUT_FILTER  16'h3367
`define SIOM_ADDR_INPUT_INVERT_A       16'h3368
`define SIOM_ADDR_IRQ_STATUS           16'h3380
`define SIOM_ADDR_IRQ_MASK             16'h3381
`define SIOM_ADDR_IO_STATE             16'h3382

// Reset values.
`define SIOM_RST_INPUT_ALLOC_A         16'h3210
`define SIOM_RST_INPUT_ALLOC_B         16'h0004
`define SIOM_RST_OUTPUT_ALLOC          16'h0210
`define SIOM_RST_BUS_INPUT_LOW_EN      16'h0000
`define SIOM_RST_BUS_INPUT_HIGH_EN     16'h0000
`define SIOM_RST_INPUT_FILTER_CYCLES   16'h0001
`define SIOM_RST_ALARM_OUTPUT_FILTER   16'h0001
`define SIOM_RST_INPUT_INVERT_A        16'h0000
`define SIOM_RST_IRQ_MASK              16'h0000

// Field layout and limits.
`define SIOM_INPUT_FILTER_MAX          16'h03e8
`define SIOM_ALARM_FILTER_MAX          16'h0003
`define SIOM_BUS_LOW_FIRST_BIT         16
`define SIOM_BUS_HIGH_BIT              24
`define SIOM_NUM_INPUTS                5
`define SIOM_NUM_FUNCS                 8
`define SIOM_NUM_OUTPUTS               3
`define SIOM_NUM_STATUS                12

// Interrupt status bits.
`define SIOM_IRQ_INPUT_CHANGE          0
`define SIOM_IRQ_ALARM_CHANGE          1
`define SIOM_IRQ_RESTART_DONE          2
`define SIOM_IRQ_WIDTH                 3

`endif

/* siom_filt.v */
// Stability filter counting control cycles before accepting a new level.
`timescale 1ns/100ps
`default_nettype none

module siom_filt (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ctrl_tick,
  input  wire [10:0] limit,
  input  wire        level_in,
  output reg         level_out
);

  reg  [10:0] count;
  wire [10:0] next_count;

  assign next_count = count + 11'h001;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count     <= 11'h000;
      level_out <= 1'b0;
    end else if (limit == 11'h000) begin
      // A zero setting bypasses filtering entirely.
      count     <= 11'h000;
      level_out <= level_in;
    end else if (ctrl_tick) begin
      if (level_in == level_out) begin
        // Any return to the old level restarts the stability count.
        count <= 11'h000;
      end else if (next_count >= limit) begin
        count     <= 11'h000;
        level_out <= level_in;
      end else begin
        count <= next_count;
      end
    end
  end

endmodule // siom_filt

`default_nettype wire

/* siom_host.sv */
// Model of the host side: control-cycle tick and fieldbus input object.
`timescale 1ns/100ps
`default_nettype none
module siom_host (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] obj_word,
  output var  logic        ctrl_tick,
  output var  logic [31:0] bus_digital_in
);
  logic [1:0] div;
  // The object is refreshed every clock, so a new word lands one cycle later.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div <= 2'd0;
      ctrl_tick <= 1'b0;
      bus_digital_in <= 32'h0000_0000;
    end else begin
      div <= div + 2'd1;
      ctrl_tick <= (div == 2'd3);
      bus_digital_in <= obj_word;
    end
  end
endmodule // siom_host
`default_nettype wire

/* siom_top.v */
// Servo I/O signal mapping: pin and bus input routing, filters and output allocation.
`timescale 1ns/100ps
`default_nettype none

`include "siom_consts.vh"

module siom_top (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ctrl_tick,
  input  wire        restart,
  input  wire [15:0] reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire [4:0]  input_pin,
  input  wire [31:0] bus_digital_in,
  output reg  [7:0]  drive_func,
  input  wire [11:0] drive_status,
  output reg  [2:0]  output_pin,
  input  wire        alarm_in,
  output wire        alarm_out,
  output wire        irq
);

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  // Settings are plain storage here; none of them acts until the logic
  // below copies it on restart or reads it live.
  reg  [15:0] input_alloc_a;
  reg  [15:0] input_alloc_b;
  reg  [15:0] output_alloc;
  reg  [15:0] bus_input_low_enable;
  reg  [15:0] bus_input_high_enable;
  reg  [15:0] input_filter_cycles;
  reg  [15:0] alarm_output_filter;
  reg  [15:0] input_invert_a;
  reg  [15:0] irq_mask;
  reg  [`SIOM_IRQ_WIDTH-1:0] irq_status;

  // Copies in use; allocation settings only take effect on restart.
  reg  [15:0] act_alloc_a;
  reg  [15:0] act_alloc_b;
  reg  [15:0] act_out_alloc;
  reg  [15:0] act_bus_low;
  reg  [15:0] act_bus_high;
  reg  [15:0] act_invert_a;

  wire        wr_hit_status;
  wire [`SIOM_IRQ_WIDTH-1:0] event_set;
  wire [`SIOM_IRQ_WIDTH-1:0] status_clear;

  // Writes land at the strobe edge and never stall the bus; writes to
  // unmapped addresses are dropped.
  assign wr_hit_status = reg_wr && (reg_addr == `SIOM_ADDR_IRQ_STATUS);
  assign status_clear  = wr_hit_status ? reg_wdata[`SIOM_IRQ_WIDTH-1:0] :
                         {`SIOM_IRQ_WIDTH{1'b0}};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      input_alloc_a         <= `SIOM_RST_INPUT_ALLOC_A;
      input_alloc_b         <= `SIOM_RST_INPUT_ALLOC_B;
      output_alloc          <= `SIOM_RST_OUTPUT_ALLOC;
      bus_input_low_enable  <= `SIOM_RST_BUS_INPUT_LOW_EN;
      bus_input_high_enable <= `SIOM_RST_BUS_INPUT_HIGH_EN;
      input_filter_cycles   <= `SIOM_RST_INPUT_FILTER_CYCLES;
      alarm_output_filter   <= `SIOM_RST_ALARM_OUTPUT_FILTER;
      input_invert_a        <= `SIOM_RST_INPUT_INVERT_A;
      irq_mask              <= `SIOM_RST_IRQ_MASK;
    end else if (reg_wr) begin
      case (reg_addr)
        `SIOM_ADDR_INPUT_ALLOC_A:       input_alloc_a         <= reg_wdata;
        `SIOM_ADDR_INPUT_ALLOC_B:       input_alloc_b         <= reg_wdata;
        `SIOM_ADDR_OUTPUT_ALLOC:        output_alloc          <= reg_wdata;
        `SIOM_ADDR_BUS_INPUT_LOW_EN:    bus_input_low_enable  <= reg_wdata;
        `SIOM_ADDR_BUS_INPUT_HIGH_EN:   bus_input_high_enable <= reg_wdata;
        `SIOM_ADDR_INPUT_FILTER_CYCLES: input_filter_cycles   <= reg_wdata;
        `SIOM_ADDR_ALARM_OUTPUT_FILTER: alarm_output_filter   <= reg_wdata;
        `SIOM_ADDR_INPUT_INVERT_A:      input_invert_a        <= reg_wdata;
        `SIOM_ADDR_IRQ_MASK:            irq_mask              <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Settings in use
  // ---------------------------------------------------------------
  // Allocation, bus source and inversion change only on a restart pulse, so
  // a half-written mapping never reaches the drive functions; the two filter
  // settings are read live from the register file instead.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_alloc_a   <= `SIOM_RST_INPUT_ALLOC_A;
      act_alloc_b   <= `SIOM_RST_INPUT_ALLOC_B;
      act_out_alloc <= `SIOM_RST_OUTPUT_ALLOC;
      act_bus_low   <= `SIOM_RST_BUS_INPUT_LOW_EN;
      act_bus_high  <= `SIOM_RST_BUS_INPUT_HIGH_EN;
      act_invert_a  <= `SIOM_RST_INPUT_INVERT_A;
    end else if (restart) begin
      act_alloc_a   <= input_alloc_a;
      act_alloc_b   <= input_alloc_b;
      act_out_alloc <= output_alloc;
      act_bus_low   <= bus_input_low_enable;
      act_bus_high  <= bus_input_high_enable;
      act_invert_a  <= input_invert_a;
    end
  end

  // ---------------------------------------------------------------
  // Input path: source select, filter, inversion
  // ---------------------------------------------------------------
  wire [4:0]  raw_in;
  wire [4:0]  filt_in;
  wire [4:0]  final_in;
  wire [4:0]  bus_sel;
  wire [4:0]  inv_sel;
  wire [3:0]  in_code [0:4];
  wire [10:0] in_limit;
  wire [10:0] alarm_limit;
  wire [15:0] in_limit_full;
  wire [15:0] alarm_max;

  // Oversized settings are clamped rather than wrapped so that a bad write
  // cannot silently shorten the filter.
  assign in_limit_full = (input_filter_cycles > `SIOM_INPUT_FILTER_MAX) ?
                         `SIOM_INPUT_FILTER_MAX : input_filter_cycles;
  assign in_limit      = in_limit_full[10:0];
  // The alarm count is kept in whole control cycles, two per setting step.
  assign alarm_max     = `SIOM_ALARM_FILTER_MAX;
  assign alarm_limit   = (alarm_output_filter > `SIOM_ALARM_FILTER_MAX) ?
                         {alarm_max[9:0], 1'b0} :
                         {alarm_output_filter[9:0], 1'b0};

  // ---------------------------------------------------------------
  // Source select
  // ---------------------------------------------------------------
  // Pin e has no inversion digit in this register, so it passes unchanged.
  assign bus_sel[4] = act_bus_high[0];
  assign inv_sel[4] = 1'b0;
  assign in_code[4] = act_alloc_b[3:0];
  assign raw_in[4]  = bus_sel[4] ? bus_digital_in[`SIOM_BUS_HIGH_BIT] : input_pin[4];

  // Inversion sits after the filter, so the stability count always works on
  // the raw level and a new inversion takes effect without a filter delay.
  genvar gi;
  generate
    for (gi = 0; gi < `SIOM_NUM_INPUTS; gi = gi + 1) begin : g_in
      if (gi < 4) begin : g_abcd
        assign bus_sel[gi] = act_bus_low[gi*4];
        assign inv_sel[gi] = act_invert_a[gi*4];
        assign in_code[gi] = act_alloc_a[gi*4+3:gi*4];
        assign raw_in[gi]  = bus_sel[gi] ? bus_digital_in[`SIOM_BUS_LOW_FIRST_BIT+gi] :
                             input_pin[gi];
      end
      siom_filt u_filt (
        .clk       (clk),
        .rst_n     (rst_n),
        .ctrl_tick (ctrl_tick),
        .limit     (in_limit),
        .level_in  (raw_in[gi]),
        .level_out (filt_in[gi])
      );
      assign final_in[gi] = filt_in[gi] ^ inv_sel[gi];
    end
  endgenerate

  siom_filt u_alarm_filt (
    .clk       (clk),
    .rst_n     (rst_n),
    .ctrl_tick (ctrl_tick),
    .limit     (alarm_limit),
    .level_in  (alarm_in),
    .level_out (alarm_out)
  );

  // ---------------------------------------------------------------
  // Function and output allocation
  // ---------------------------------------------------------------
  // Outputs are registered so that the drive sees clean levels even in the
  // cycle in which an allocation copy changes on restart.
  reg [7:0] next_drive_func;
  reg [2:0] next_output_pin;
  reg [3:0] out_code;
  integer   fi;
  integer   ii;

  always @* begin
    next_drive_func = 8'h00;
    next_output_pin = 3'b000;
    out_code        = 4'h0;
    // Several pins on one function are ORed; codes above seven drive nothing.
    for (fi = 0; fi < `SIOM_NUM_FUNCS; fi = fi + 1) begin
      for (ii = 0; ii < `SIOM_NUM_INPUTS; ii = ii + 1) begin
        if (in_code[ii] == fi[3:0] && final_in[ii]) begin
          next_drive_func[fi] = 1'b1;
        end
      end
    end
    // Status codes past the last wired status leave the pin low.
    for (ii = 0; ii < `SIOM_NUM_OUTPUTS; ii = ii + 1) begin
      out_code = act_out_alloc[ii*4 +: 4];
      if (out_code < `SIOM_NUM_STATUS) begin
        next_output_pin[ii] = drive_status[out_code];
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_func <= 8'h00;
      output_pin <= 3'b000;
    end else begin
      drive_func <= next_drive_func;
      output_pin <= next_output_pin;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  // Each edge detector starts from the reset level of its source, so the
  // release of reset itself raises no event.
  reg [4:0] prev_in;
  reg       prev_alarm;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_in    <= 5'b00000;
      prev_alarm <= 1'b0;
    end else begin
      prev_in    <= final_in;
      prev_alarm <= alarm_out;
    end
  end

  assign event_set[`SIOM_IRQ_INPUT_CHANGE] = (prev_in != final_in);
  assign event_set[`SIOM_IRQ_ALARM_CHANGE] = (prev_alarm != alarm_out);
  assign event_set[`SIOM_IRQ_RESTART_DONE] = restart;

  // A new event in the same cycle as its clear keeps the bit set.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= {`SIOM_IRQ_WIDTH{1'b0}};
    end else begin
      irq_status <= (irq_status & ~status_clear) | event_set;
    end
  end

  // The interrupt is a plain level: software must clear a status bit before
  // it can see a second event of the same kind.
  assign irq = |(irq_status & irq_mask[`SIOM_IRQ_WIDTH-1:0]);

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Read data stand for one cycle and then fall back to zero, so a stale
  // word can never be taken for a fresh read.
  reg [15:0] next_rdata;

  always @* begin
    case (reg_addr)
      `SIOM_ADDR_INPUT_ALLOC_A:       next_rdata = input_alloc_a;
      `SIOM_ADDR_INPUT_ALLOC_B:       next_rdata = input_alloc_b;
      `SIOM_ADDR_OUTPUT_ALLOC:        next_rdata = output_alloc;
      `SIOM_ADDR_BUS_INPUT_LOW_EN:    next_rdata = bus_input_low_enable;
      `SIOM_ADDR_BUS_INPUT_HIGH_EN:   next_rdata = bus_input_high_enable;
      `SIOM_ADDR_INPUT_FILTER_CYCLES: next_rdata = input_filter_cycles;
      `SIOM_ADDR_ALARM_OUTPUT_FILTER: next_rdata = alarm_output_filter;
      `SIOM_ADDR_INPUT_INVERT_A:      next_rdata = input_invert_a;
      `SIOM_ADDR_IRQ_STATUS:          next_rdata = {13'h0000, irq_status};
      `SIOM_ADDR_IRQ_MASK:            next_rdata = irq_mask;
      `SIOM_ADDR_IO_STATE:            next_rdata = {alarm_out, output_pin, drive_func, 4'h0};
      default:                        next_rdata = 16'h0000;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule // siom_top

`default_nettype wire

/* siom_top_end.v */
// Closing file of the block; it holds no logic of its own.
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* siom_top_monitor.sv */
// Port checker for the servo I/O signal mapping block.
`timescale 1ns/100ps
`default_nettype none
`include "siom_consts.vh"
module siom_top_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ctrl_tick,
  input wire logic        restart,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [4:0]  input_pin,
  input wire logic [31:0] bus_digital_in,
  input wire logic [7:0]  drive_func,
  input wire logic [11:0] drive_status,
  input wire logic [2:0]  output_pin,
  input wire logic        alarm_in,
  input wire logic        alarm_out,
  input wire logic        irq
);
  // ------------------------------------------------------------
  // Output allocation shadow: written value and value in use.
  // ------------------------------------------------------------
  logic [1:0]  age;
  logic [15:0] oa_new;
  logic [15:0] oa_use;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      age <= 2'd0;
      oa_new <= `SIOM_RST_OUTPUT_ALLOC;
      oa_use <= `SIOM_RST_OUTPUT_ALLOC;
    end else begin
      if (age != 2'd3) age <= age + 2'd1;
      if (reg_wr && reg_addr == `SIOM_ADDR_OUTPUT_ALLOC) oa_new <= reg_wdata;
      if (restart) oa_use <= oa_new;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data not idle");
  unmapped_read_a: assert property (
    $past(reg_rd) && $past(reg_addr[15:8]) != 8'h33 |-> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  alloc_read_a: assert property (
    $past(reg_rd) && $past(reg_addr) == `SIOM_ADDR_OUTPUT_ALLOC |-> reg_rdata == $past(oa_new))
    else $error("output allocation readback wrong");
  output_map_a: assert property (age == 2'd3 |-> output_pin ==
    {$past(drive_status[oa_use[11:8]]), $past(drive_status[oa_use[7:4]]),
     $past(drive_status[oa_use[3:0]])}) else $error("output pin map wrong");
  alarm_follow_a: assert property (
    age == 2'd3 && $changed(alarm_out) |-> alarm_out == $past(alarm_in))
    else $error("alarm output took a level not seen");
  alarm_hold_a: assert property (
    (age == 2'd3 && !ctrl_tick && !reg_wr && $stable(alarm_in))[*2] |=> $stable(alarm_out))
    else $error("alarm output moved without cause");
  input_hold_a: assert property ((age == 2'd3 && !ctrl_tick && !reg_wr && !restart
    && $stable(input_pin) && $stable(bus_digital_in))[*3] |=> $stable(drive_func))
    else $error("drive function moved without cause");
  irq_clear_a: assert property (
    $fell(irq) |-> $past(reg_wr)) else $error("interrupt fell without a write");
endmodule // siom_top_monitor
bind siom_top siom_top_monitor u_mon (.clk(clk), .rst_n(rst_n), .ctrl_tick(ctrl_tick),
  .restart(restart), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .input_pin(input_pin),
  .bus_digital_in(bus_digital_in), .drive_func(drive_func), .drive_status(drive_status),
  .output_pin(output_pin), .alarm_in(alarm_in), .alarm_out(alarm_out), .irq(irq));
`default_nettype wire

/* test_servo_io_signal_mapping.sv */
// Self-checking testbench for the servo I/O signal mapping block.
`timescale 1ns/100ps
`default_nettype none
`include "siom_consts.vh"
module test_servo_io_signal_mapping;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        restart = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        alarm_in = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic [4:0]  input_pin = 5'h00;
  logic [11:0] drive_status = 12'h000;
  logic [31:0] obj_word = 32'h0000_0000;
  wire  logic        ctrl_tick;
  wire  logic        alarm_out;
  wire  logic        irq;
  wire  logic [31:0] bus_digital_in;
  wire  logic [15:0] reg_rdata;
  wire  logic [7:0]  drive_func;
  wire  logic [2:0]  output_pin;
  int          failures = 0;
  int          cmp_count = 0;
  logic [15:0] ra [11] = '{16'h3361, 16'h3362, 16'h3363, 16'h3364, 16'h3365,
                           16'h3366, 16'h3367, 16'h3368, 16'h3381, 16'h3300, 16'h1200};
  logic [15:0] rv [11] = '{16'h3210, 16'h0004, 16'h0210, 16'h0000, 16'h0000,
                           16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  siom_host host (.clk(clk), .rst_n(rst_n), .obj_word(obj_word), .ctrl_tick(ctrl_tick),
    .bus_digital_in(bus_digital_in));
  siom_top dut (.clk(clk), .rst_n(rst_n), .ctrl_tick(ctrl_tick), .restart(restart),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .input_pin(input_pin), .bus_digital_in(bus_digital_in),
    .drive_func(drive_func), .drive_status(drive_status), .output_pin(output_pin),
    .alarm_in(alarm_in), .alarm_out(alarm_out), .irq(irq));
  initial forever #20 clk = ~clk;
  // ------------------------------------------------------------
  // Shared bus, wait and compare tasks.
  // ------------------------------------------------------------
  task automatic give_verdict();
    if (failures == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken at its end.
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
  task automatic pulse_restart();
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
  endtask
  task automatic wait_tick();
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      if (ctrl_tick === 1'b1) return;
    end
    failures++;
    give_verdict();
  endtask
  task automatic check_in(input logic [4:0] p, input logic [31:0] o, input logic [7:0] e);
    @(posedge clk);
    input_pin <= p;
    obj_word <= o;
    repeat (5) @(posedge clk);
    chk("drive_func", e, drive_func);
  endtask
  // ------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [15:0] d;
    for (int i = 0; i < 11; i++) begin
      rd(ra[i], d);
      chk("reset value", rv[i], d);
    end
  endtask
  task automatic t_bus();
    wr(`SIOM_ADDR_INPUT_FILTER_CYCLES, 16'h0000);
    wr(`SIOM_ADDR_BUS_INPUT_LOW_EN, 16'h1111);
    wr(`SIOM_ADDR_BUS_INPUT_HIGH_EN, 16'h0001);
    pulse_restart();
    check_in(5'h1f, 32'h0000_0000, 8'h00);
    for (int i = 0; i < 4; i++) check_in(5'h00, 32'h1 << (16 + i), 8'h1 << i);
    check_in(5'h00, 32'h0100_0000, 8'h10);
    wr(`SIOM_ADDR_BUS_INPUT_LOW_EN, 16'h0000);
    wr(`SIOM_ADDR_BUS_INPUT_HIGH_EN, 16'h0000);
    pulse_restart();
    check_in(5'h00, 32'h0000_0000, 8'h00);
  endtask
  task automatic t_filter();
    wr(`SIOM_ADDR_INPUT_FILTER_CYCLES, 16'h0003);
    @(posedge clk);
    input_pin <= 5'h01;
    wait_tick();
    wait_tick();
    repeat (2) @(posedge clk);
    chk("filtered early", 8'h00, drive_func);
    wait_tick();
    repeat (2) @(posedge clk);
    chk("filtered late", 8'h01, drive_func);
    wr(`SIOM_ADDR_INPUT_FILTER_CYCLES, 16'h0000);
  endtask
  task automatic t_remap();
    logic [15:0] d;
    wr(`SIOM_ADDR_INPUT_ALLOC_A, 16'h7655);
    wr(`SIOM_ADDR_INPUT_ALLOC_B, 16'h3003);
    wr(`SIOM_ADDR_INPUT_INVERT_A, 16'h0001);
    check_in(5'h02, 32'h0000_0000, 8'h02);
    pulse_restart();
    check_in(5'h00, 32'h0000_0000, 8'h20);
    check_in(5'h02, 32'h0000_0000, 8'h20);
    check_in(5'h10, 32'h0000_0000, 8'h28);
    check_in(5'h0d, 32'h0000_0000, 8'hc0);
    rd(`SIOM_ADDR_INPUT_ALLOC_B, d);
    chk("input_alloc_b reserved digit", 16'h3003, d);
  endtask
  task automatic t_output();
    logic [15:0] d;
    @(posedge clk);
    drive_status <= 12'h808;
    wr(`SIOM_ADDR_OUTPUT_ALLOC, 16'h0b73);
    repeat (3) @(posedge clk);
    chk("output before restart", 3'b000, output_pin);
    pulse_restart();
    repeat (3) @(posedge clk);
    chk("output after restart", 3'b101, output_pin);
    drive_status <= 12'h080;
    repeat (3) @(posedge clk);
    chk("output status 7", 3'b010, output_pin);
    rd(`SIOM_ADDR_OUTPUT_ALLOC, d);
    chk("output_alloc", 16'h0b73, d);
    rd(`SIOM_ADDR_IO_STATE, d);
    chk("io state", 16'h2c00, d);
  endtask
  task automatic t_alarm();
    logic [15:0] d;
    wr(`SIOM_ADDR_ALARM_OUTPUT_FILTER, 16'h0002);
    @(posedge clk);
    alarm_in <= 1'b1;
    repeat (3) wait_tick();
    @(posedge clk);
    chk("alarm early", 1'b0, alarm_out);
    wait_tick();
    @(posedge clk);
    chk("alarm late", 1'b1, alarm_out);
    repeat (3) @(posedge clk);
    chk("irq masked", 1'b0, irq);
    wr(`SIOM_ADDR_IRQ_MASK, 16'h0002);
    repeat (2) @(posedge clk);
    chk("irq raised", 1'b1, irq);
    wr(`SIOM_ADDR_IRQ_STATUS, 16'h0002);
    repeat (2) @(posedge clk);
    chk("irq cleared", 1'b0, irq);
    rd(`SIOM_ADDR_IRQ_STATUS, d);
    chk("irq status", 16'h0005, d);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_bus();
    t_filter();
    t_remap();
    t_output();
    t_alarm();
    give_verdict();
  end
endmodule // test_servo_io_signal_mapping
`default_nettype wire
